// File: spi_master_slave_port.sv
// Behaviour
// - Master shifts bytes out on master-out line, MSB first.
// - Slave shifts bytes out on master-in line, MSB first.
// - As master, exactly eight serial clock cycles per byte transfer.
// - Deselected slave leaves its master-in output undriven.
// - As master, own select input is expected high.
// - Master with select low raises mode fault, stops driving lines.
// - Mode fault can raise the interrupt.
// - Master with select disable ignores select pin; no mode fault.
// - Slave with phase and select disable set is always selected.
// - Clearing select disable leaves mode fault flag untouched.
// - Master clock is internal clock divided by 2 to 128.
// - Clock polarity and phase are software programmable.
// - Data write during a transfer sets write collision flag.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "spi_port_regs.svh"
module spi_master_slave_port #(
	parameter int BITS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic ss_n_i,
	output logic irq
);
	if (BITS < 2 || BITS > 16)
	begin : g_chk
		$error("BITS must lie in 2..16");
	end

	logic [7:0] ctrl_reg;
	logic [2:0] ie_reg, st_reg, st_next;
	logic [BITS-1:0] tx_reg, rx_reg, rx_buf_reg, rx_next;
	spi_port_pkg::xfer_state_t state_reg;
	logic [5:0] edge_cnt_reg;
	logic [6:0] div_cnt_reg;
	logic sck_reg, sck_prev_reg;
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	logic [4:0] awaddr_reg;
	logic [15:0] wdata_reg;
	logic wlane_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	wire logic [2:0] rate = ctrl_reg[`CTRL_RATE_HI:`CTRL_RATE_LO];
	wire logic clock_phase_select = ctrl_reg[`CTRL_CLOCK_PHASE_SELECT];
	wire logic cpol = ctrl_reg[`CTRL_CPOL];
	wire logic master = ctrl_reg[`CTRL_MSTR];
	wire logic select_pin_disable = ctrl_reg[`CTRL_SELECT_PIN_DISABLE];
	wire logic enable = ctrl_reg[`CTRL_EN];
	wire logic mode_fault_flag = st_reg[`ST_MODE_FAULT_FLAG];
	wire logic run = state_reg == spi_port_pkg::XFER_RUN;

	// AXI4-Lite decode
	wire logic wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire logic ar_fire = arvalid & ~rvalid_reg;
	wire logic wa_ctrl = awaddr_reg == `OFS_CTRL;
	wire logic wa_data = awaddr_reg == `OFS_DATA;
	wire logic wa_ie = awaddr_reg == `OFS_IE;
	wire logic wa_clr = awaddr_reg == `OFS_CLR;
	wire logic wa_ok = wa_ctrl | wa_data | wa_ie | wa_clr | (awaddr_reg == `OFS_STAT);
	wire logic wr_en = wr_fire & wlane_reg;
	wire logic wr_ctrl = wr_en & wa_ctrl;
	wire logic wr_data = wr_en & wa_data;
	wire logic wr_ie = wr_en & wa_ie;
	wire logic [2:0] clr_bits = (wr_en & wa_clr) ? wdata_reg[2:0] : 3'h0;
	assign awready = ~aw_hold_reg & ~bvalid_reg;
	assign wready = ~w_hold_reg & ~bvalid_reg;
	assign arready = ~rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	// Serial engine
	wire logic force_sel = ~master & clock_phase_select & select_pin_disable;
	wire logic sel = enable & ~master & (~ss_n_i | force_sel);
	wire logic mf_ev = enable & master & ~select_pin_disable & ~ss_n_i;
	wire logic drive_ok = enable & master & ~mode_fault_flag;
	wire logic [6:0] half = 7'(7'h01 << rate);
	wire logic m_tick = run & master & (div_cnt_reg == half - 7'h01);
	wire logic s_edge = run & ~master & (sck_i != sck_prev_reg);
	wire logic edge_ev = m_tick | s_edge;
	wire logic leading = ~edge_cnt_reg[0];
	wire logic sample_ev = edge_ev & (leading ^ clock_phase_select);
	// Phase 1 shifts on leading edges, but the first one must keep the MSB
	wire logic shift_ev = edge_ev & ~(leading ^ clock_phase_select) & ~(clock_phase_select & edge_cnt_reg == 6'h00);
	wire logic last_ev = edge_ev & (edge_cnt_reg == 6'(2 * BITS - 1));
	wire logic busy = run & (master | edge_cnt_reg != 6'h00);
	wire logic din = master ? miso_i : mosi_i;
	wire logic m_start = wr_data & ~busy & drive_ok & rate != `RATE_RSVD;
	wire logic s_start = ~run & sel;
	wire logic s_drop = run & ~master & ~sel;
	wire logic [2:0] st_set = {mf_ev, wr_data & busy, last_ev};
	assign rx_next = {rx_reg[BITS-2:0], din};
	assign st_next = (st_reg & ~clr_bits) | st_set;
	assign sck_o = sck_reg;
	assign sck_oe = drive_ok;
	assign mosi_o = tx_reg[BITS-1];
	assign mosi_oe = drive_ok;
	assign miso_o = tx_reg[BITS-1];
	assign miso_oe = sel;
	assign irq = |(st_reg & ie_reg);

	wire logic [31:0] rd_mux =
		(araddr == `OFS_CTRL) ? {24'h000000, ctrl_reg} :
		(araddr == `OFS_STAT) ? {28'h0000000, busy, st_reg} :
		(araddr == `OFS_DATA) ? {16'h0000, 16'(rx_buf_reg)} :
		(araddr == `OFS_IE) ? {29'h0000000, ie_reg} : 32'h00000000;
	wire logic ra_ok = araddr == `OFS_CTRL || araddr == `OFS_STAT || araddr == `OFS_DATA ||
		araddr == `OFS_IE || araddr == `OFS_CLR;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			awaddr_reg <= 5'h00;
			wdata_reg <= 16'h0000;
			wlane_reg <= 1'b0;
			bresp_reg <= `RESP_OK;
			rresp_reg <= `RESP_OK;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			if (awvalid & awready)
			begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= awaddr;
			end
			else if (wr_fire)
				aw_hold_reg <= 1'b0;
			if (wvalid & wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg <= wdata[15:0];
				wlane_reg <= wstrb[0];
			end
			else if (wr_fire)
				w_hold_reg <= 1'b0;
			if (wr_fire)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wa_ok ? `RESP_OK : `RESP_SLVERR;
			end
			else if (bready)
				bvalid_reg <= 1'b0;
			if (ar_fire)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= ra_ok ? `RESP_OK : `RESP_SLVERR;
			end
			else if (rready)
				rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= `CTRL_RESET;
			ie_reg <= 3'h0;
			st_reg <= 3'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= wdata_reg[7:0];
			if (wr_ie)
				ie_reg <= wdata_reg[2:0];
			st_reg <= st_next;
		end
	end

	// A mode fault aborts at once; a slave losing select mid-byte drops the partial byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= spi_port_pkg::XFER_IDLE;
			edge_cnt_reg <= 6'h00;
			div_cnt_reg <= 7'h00;
			sck_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			tx_reg <= '0;
			rx_reg <= '0;
			rx_buf_reg <= '0;
		end
		else
		begin
			sck_prev_reg <= sck_i;
			if (wr_data & ~busy)
				tx_reg <= BITS'(wdata_reg);
			else if (shift_ev)
				tx_reg <= {tx_reg[BITS-2:0], 1'b0};
			if (sample_ev)
				rx_reg <= rx_next;
			if (last_ev)
				rx_buf_reg <= sample_ev ? rx_next : rx_reg;
			div_cnt_reg <= (~run | m_tick) ? 7'h00 : div_cnt_reg + 7'h01;
			if (~run | ~master)
				sck_reg <= cpol;
			else if (m_tick)
				sck_reg <= ~sck_reg;
			if (mf_ev | last_ev | s_drop)
			begin
				state_reg <= spi_port_pkg::XFER_IDLE;
				edge_cnt_reg <= 6'h00;
			end
			else if (m_start | s_start)
			begin
				state_reg <= spi_port_pkg::XFER_RUN;
				edge_cnt_reg <= 6'h00;
			end
			else if (edge_ev)
				edge_cnt_reg <= edge_cnt_reg + 6'h01;
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic sck_d_reg;
	logic [5:0] tog_cnt_reg;
	always_ff @(posedge aclk)
	begin
		sck_d_reg <= sck_o;
		if (m_start)
			tog_cnt_reg <= 6'h00;
		else if (sck_o != sck_d_reg)
			tog_cnt_reg <= tog_cnt_reg + 6'h01;
	end

	property p_tristate;
		enable && !master && ss_n_i && !force_sel |-> !miso_oe;
	endproperty
	a_tristate: assert property (p_tristate) else $error("slave drives miso while deselected");

	property p_mode_fault_flag_set;
		enable && master && !select_pin_disable && !ss_n_i |=> mode_fault_flag && !sck_oe && !mosi_oe && !run;
	endproperty
	a_mode_fault_flag_set: assert property (p_mode_fault_flag_set) else $error("mode fault not raised");

	property p_no_mode_fault_flag;
		$rose(mode_fault_flag) |-> $past(master) && !$past(select_pin_disable);
	endproperty
	a_no_mode_fault_flag: assert property (p_no_mode_fault_flag) else $error("mode fault with select disabled");

	property p_mode_fault_flag_keep;
		mode_fault_flag && !(wr_en && wa_clr && wdata_reg[`ST_MODE_FAULT_FLAG]) |=> mode_fault_flag;
	endproperty
	a_mode_fault_flag_keep: assert property (p_mode_fault_flag_keep) else $error("mode fault lost");

	property p_irq;
		mode_fault_flag && ie_reg[`ST_MODE_FAULT_FLAG] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("mode fault interrupt missing");

	property p_wcol;
		wr_data && busy |=> st_reg[`ST_WCOL];
	endproperty
	a_wcol: assert property (p_wcol) else $error("write collision not flagged");

	sequence s_start_msb;
		m_start ##1 mosi_o == $past(wdata_reg[BITS-1]);
	endsequence
	property p_msb;
		m_start |-> s_start_msb;
	endproperty
	a_msb: assert property (p_msb) else $error("first bit is not the msb");

	property p_eight;
		$fell(run) && $past(master) && !mode_fault_flag |=> tog_cnt_reg == 6'(2 * BITS);
	endproperty
	a_eight: assert property (p_eight) else $error("wrong serial clock count");

	property p_div2;
		run && master && rate == 3'h0 && $changed(sck_o) |=> $changed(sck_o) || !run;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two rate broken");

	property p_rsvd;
		wr_data && !busy && rate == `RATE_RSVD |=> !run;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved rate started a transfer");

	property p_idle_pol;
		!run ##1 !run |-> sck_o == $past(cpol);
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong");

	property p_forced;
		enable && !master && clock_phase_select && select_pin_disable && !run |=> run;
	endproperty
	a_forced: assert property (p_forced) else $error("forced select not honoured");
endmodule // spi_master_slave_port

// File: spi_port_pkg.sv
package spi_port_pkg;
	typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;
endpackage

// File: spi_port_regs.svh
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH
`define OFS_CTRL 5'h00
`define OFS_STAT 5'h04
`define OFS_DATA 5'h08
`define OFS_IE 5'h0c
`define OFS_CLR 5'h10
`define CTRL_RATE_LO 0
`define CTRL_RATE_HI 2
`define CTRL_CLOCK_PHASE_SELECT 3
`define CTRL_CPOL 4
`define CTRL_MSTR 5
`define CTRL_SELECT_PIN_DISABLE 6
`define CTRL_EN 7
`define CTRL_RESET 8'h00
`define ST_DONE 0
`define ST_WCOL 1
`define ST_MODE_FAULT_FLAG 2
`define ST_BUSY 3
`define RATE_RSVD 3'h7
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh;
	initial miso = 1'b0;
	initial rx = 8'h00;
	initial sh = 8'h00;
	// First bit must be out before the first leading edge
	always @(negedge ss_n)
	begin
		sh = tx;
		miso = tx[7];
	end
	// MSB first in
	always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!ss_n)
	begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
	// Released line never shows the last bit
	always @(posedge ss_n) miso = ~miso;
endmodule // spi_slave_model

// File: test_spi_master_slave_port.sv
`timescale 1ns/1ps
`include "spi_port_regs.svh"
module test_spi_master_slave_port;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ss_n_i, sel_n, s_sck, s_mosi;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, v, t, de, me;
	logic [3:0] wstrb;
	logic [1:0] re, bresp, rresp;
	logic [7:0] stx, srx, sx, sy;
	logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, miso;
	logic [31:0] rdata;
	wire sck = sck_oe ? sck_o : 1'b0;
	int err_count, n_compared, nsck, nhi;
	logic [65:0] q[$];
	spi_master_slave_port spi_master_slave_port_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sck_i(s_sck), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(s_mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(ss_n_i), .irq(irq));
	spi_slave_model spi_slave_model_inst (.sck(sck), .mosi(mosi_o), .ss_n(sel_n), .tx(stx), .miso(miso), .rx(srx));
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge sck) nsck++;
	always @(posedge aclk) if (sck_o) nhi++;
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tmo();
		err_count++;
		$display("[ERR] %0t wait ran out", $time);
		results();
	endtask
	// Results are judged in the order the reads were issued
	always @(posedge aclk)
		if (rvalid && rready)
		begin
			{re, de, me} = q.pop_front();
			if (me != 0) chk(rdata & me, de);
			chk(rresp, re);
		end
	// One edge passes first so a back-to-back call never re-raises a strobe in the same step
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int i;
		logic b;
		@(posedge aclk);
		b = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50 && b; i++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
			if (bvalid) b = 1'b0;
		end
		if (b) tmo();
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, m, input logic [1:0] r = 2'h0);
		int i;
		logic got;
		@(posedge aclk);
		got = 1'b0;
		q.push_back({r, e, m});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50 && !got; i++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) v = rdata;
			if (rvalid) rready <= 1'b0;
			if (rvalid) got = 1'b1;
		end
		if (!got) tmo();
	endtask
	task automatic wait_done();
		int i;
		for (i = 0; i < 100; i++)
		begin
			rd(`OFS_STAT, 0, 0);
			if (v[0]) break;
		end
		if (i == 100) tmo();
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, stx, s_sck, s_mosi} = '0;
		{ss_n_i, sel_n, wstrb} = 6'h3f;
		void'($urandom(67));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OFS_CTRL, 0, 32'hff);
		rd(`OFS_STAT, 0, 32'hf);
		rd(5'h14, 0, 32'hffffffff, 2'h2);
		$display("Reset and map test done");
		wr(`OFS_IE, 1);
		for (int r = 0; r < 3; r++)
		begin
			t = $urandom;
			stx <= 8'($urandom);
			wr(`OFS_CTRL, 32'ha0 | r);
			sel_n <= 1'b0;
			nsck = 0;
			nhi = 0;
			wr(`OFS_DATA, t);
			wait_done();
			chk(irq, 1);
			sel_n <= 1'b1;
			chk(nsck, 8);
			chk(nhi, 8 << r);
			chk(srx, t[7:0]);
			rd(`OFS_DATA, stx, 32'hff);
			wr(`OFS_CLR, 7);
			chk(irq, 0);
		end
		$display("Transfer test done");
		stx <= 8'h5a;
		wr(`OFS_CTRL, 32'ha2);
		sel_n <= 1'b0;
		wr(`OFS_DATA, 8'h3c);
		wr(`OFS_DATA, 8'hc3);
		rd(`OFS_STAT, 32'ha, 32'ha);
		wait_done();
		chk(srx, 8'h3c);
		sel_n <= 1'b1;
		wr(`OFS_CLR, 7);
		wr(`OFS_CTRL, 32'ha7);
		wr(`OFS_DATA, 8'h11);
		repeat (4) @(posedge aclk);
		rd(`OFS_STAT, 0, 32'h9);
		wr(`OFS_CTRL, 32'hb0);
		@(posedge aclk);
		chk(sck_o, 1);
		$display("Collision, rate and polarity test done");
		wr(`OFS_IE, 4);
		wr(`OFS_CTRL, 32'ha0);
		ss_n_i <= 1'b0;
		repeat (2) @(posedge aclk);
		rd(`OFS_STAT, 4, 4);
		chk({sck_oe, mosi_oe}, 0);
		chk(irq, 1);
		ss_n_i <= 1'b1;
		wr(`OFS_CTRL, 32'he8);
		wr(`OFS_CTRL, 32'ha0);
		rd(`OFS_STAT, 4, 4);
		wr(`OFS_CLR, 4);
		chk(irq, 0);
		wr(`OFS_CTRL, 32'he8);
		ss_n_i <= 1'b0;
		repeat (2) @(posedge aclk);
		rd(`OFS_STAT, 0, 32'h5);
		chk(sck_oe, 1);
		ss_n_i <= 1'b1;
		wr(`OFS_CTRL, 32'h80);
		chk(miso_oe, 0);
		ss_n_i <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(miso_oe, 1);
		sx = 8'($urandom);
		sy = 8'($urandom);
		wr(`OFS_DATA, sx);
		// Bench plays master on sck_i and mosi_i, four clocks per half period
		for (int k = 7; k >= 0; k--)
		begin
			s_mosi <= sy[k];
			repeat (4) @(posedge aclk);
			chk(miso_o, sx[k]);
			s_sck <= 1'b1;
			repeat (4) @(posedge aclk);
			s_sck <= 1'b0;
		end
		rd(`OFS_DATA, sy, 32'hff);
		rd(`OFS_STAT, 1, 1);
		ss_n_i <= 1'b1;
		wr(`OFS_CTRL, 32'hc8);
		chk(miso_oe, 1);
		$display("Fault and select test done");
		results();
	end
endmodule // test_spi_master_slave_port
